// ### design/atcrb_pkg.sv
/*
 package of the auxiliary timer: register byte offsets, control field
 positions, reset values and clock divisors.
 assumes a 20 MHz system clock, which is also the oscillator rate.
*/
package atcrb_pkg;
   // register byte offsets
   localparam logic [7:0] ATCRB_ADDR_CONTROL   = 8'hc8;
   localparam logic [7:0] ATCRB_ADDR_CNT_LOW   = 8'hcc;
   localparam logic [7:0] ATCRB_ADDR_CNT_HIGH  = 8'hd0;
   localparam logic [7:0] ATCRB_ADDR_HOLD_LOW  = 8'hd4;
   localparam logic [7:0] ATCRB_ADDR_HOLD_HIGH = 8'hd8;
   localparam logic [7:0] ATCRB_ADDR_IRQ_STAT  = 8'hdc;
   localparam logic [7:0] ATCRB_ADDR_IRQ_CLR   = 8'he0;
   localparam logic [7:0] ATCRB_ADDR_IRQ_EN    = 8'he4;

   // control field positions
   localparam int ATCRB_B_OVF_FLAG = 7;
   localparam int ATCRB_B_EXT_FLAG = 6;
   localparam int ATCRB_B_RX_SEL   = 5;
   localparam int ATCRB_B_TX_SEL   = 4;
   localparam int ATCRB_B_EXT_EN   = 3;
   localparam int ATCRB_B_RUN      = 2;
   localparam int ATCRB_B_SRC_SEL  = 1;
   localparam int ATCRB_B_CAP_SEL  = 0;

   // interrupt status, clear and enable layout
   localparam int ATCRB_I_OVF = 0;
   localparam int ATCRB_I_EXT = 1;

   // reset values
   localparam logic [7:0]  ATCRB_RST_CONTROL = 8'h00;
   localparam logic [15:0] ATCRB_RST_COUNT   = 16'h0000;
   localparam logic [15:0] ATCRB_RST_HOLD    = 16'h0000;
   localparam logic [1:0]  ATCRB_RST_IRQ_EN  = 2'h0;

   // clock rates and divisors
   localparam int          ATCRB_CLK_HZ      = 20_000_000;
   localparam int          ATCRB_MC_PERIODS  = 12;
   localparam int          ATCRB_ST_PERIODS  = 2;
   localparam logic [3:0]  ATCRB_MC_LAST     = 4'(ATCRB_MC_PERIODS - 1);
   localparam logic [15:0] ATCRB_COUNT_MAX   = 16'hffff;
   localparam logic [7:0]  ATCRB_HIGH_MAX    = 8'hff;

   // serial modes that take a variable baud clock
   localparam logic [1:0]  ATCRB_SER_MODE1   = 2'h1;
   localparam logic [1:0]  ATCRB_SER_MODE3   = 2'h3;
endpackage

// ### design/atcrb_top.sv
/*
 auxiliary 16-bit timer/counter with holding register pair: capture,
 automatic reload and baud generation, plus a small interrupt block.
 assumes one 20 MHz clock, inputs synchronous to it, and a plain
 register port whose master never needs a wait state.
*/
// Notes on behaviour
// - 16-bit count in two bytes, holding pair
// - source: machine cycles or event pin falls
// - run bit low stops counting; a trigger reload still loads holding
// - overflow flag hardware set, software clear, not baud
// - trigger capture/reload sets external flag
// - enabled flags raise the shared interrupt
// - receive select routes own overflows, else other's
// - transmit select likewise, independent of receive
// - trigger used only if enabled, also in baud mode
// - capture/reload select ignored in baud mode
// - capture copies count bytes to holding bytes
// - reload mode: overflow sets flag, loads holding
// - reload mode trigger also loads holding
// - baud mode reloads on high roll, half clock
// - baud rate is overflow rate over 16
// - baud mode trigger only sets external flag
// - machine cycle is twelve clock periods
`timescale 1ns/1ps
`default_nettype none
module atcrb_top (
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_b_i,
   // register port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   // pins
   input  wire logic       ext_event_pin_i,
   input  wire logic       ext_trigger_pin_i,
   // serial port side
   input  wire logic [1:0] serial_mode_i,
   input  wire logic       other_timer_ovf_i,
   output logic            rx_baud_clk_o,
   output logic            tx_baud_clk_o,
   output logic            own_ovf_o,
   // interrupt
   output logic            irq_o
);
   import atcrb_pkg::*;

   logic [7:0]  ctrl_r;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic [15:0] hold_r;
   logic [15:0] hold_nxt;
   logic [1:0]  irq_en_r;
   logic [3:0]  mc_cnt_r;
   logic        st_cnt_r;
   logic        event_prev_r;
   logic        trig_prev_r;
   logic [7:0]  rdata_r;
   logic        rx_baud_r;
   logic        tx_baud_r;
   logic        own_ovf_r;
   logic        irq_r;
   logic        ovf_flag_nxt;
   logic        ext_flag_nxt;

   // control fields
   wire ovf_flag    = ctrl_r[ATCRB_B_OVF_FLAG];
   wire ext_flag    = ctrl_r[ATCRB_B_EXT_FLAG];
   wire rx_sel      = ctrl_r[ATCRB_B_RX_SEL];
   wire tx_sel      = ctrl_r[ATCRB_B_TX_SEL];
   wire ext_en      = ctrl_r[ATCRB_B_EXT_EN];
   wire run         = ctrl_r[ATCRB_B_RUN];
   wire src_sel     = ctrl_r[ATCRB_B_SRC_SEL];
   wire cap_sel     = ctrl_r[ATCRB_B_CAP_SEL];
   wire baud_mode   = rx_sel | tx_sel;

   // address decode
   wire wr_ctrl     = reg_wr_i & (reg_addr_i == ATCRB_ADDR_CONTROL);
   wire wr_cnt_lo   = reg_wr_i & (reg_addr_i == ATCRB_ADDR_CNT_LOW);
   wire wr_cnt_hi   = reg_wr_i & (reg_addr_i == ATCRB_ADDR_CNT_HIGH);
   wire wr_hold_lo  = reg_wr_i & (reg_addr_i == ATCRB_ADDR_HOLD_LOW);
   wire wr_hold_hi  = reg_wr_i & (reg_addr_i == ATCRB_ADDR_HOLD_HIGH);
   wire wr_irq_clr  = reg_wr_i & (reg_addr_i == ATCRB_ADDR_IRQ_CLR);
   wire wr_irq_en   = reg_wr_i & (reg_addr_i == ATCRB_ADDR_IRQ_EN);

   wire mc_tick     = (mc_cnt_r == ATCRB_MC_LAST);
   // state time tick, half the clock
   wire st_tick     = st_cnt_r;

   wire event_fall  = event_prev_r & ~ext_event_pin_i;
   wire trig_fall   = trig_prev_r & ~ext_trigger_pin_i;

   wire timer_tick  = baud_mode ? st_tick : mc_tick;
   wire src_tick    = src_sel ? event_fall : timer_tick;
   wire inc         = run & src_tick;
   wire roll        = inc & (count_r == ATCRB_COUNT_MAX);

   wire trig_evt    = ext_en & trig_fall;
   wire cap_mode    = cap_sel & ~baud_mode;
   wire do_capture  = trig_evt & cap_mode;
   // reload on trigger, not while clocking serial
   wire trig_reload = trig_evt & ~cap_mode & ~baud_mode;
   // reload on overflow in reload and baud modes
   wire ovf_reload  = roll & ~cap_mode;
   wire do_reload   = ovf_reload | trig_reload;

   // overflow flag never set in baud mode
   wire ovf_set     = roll & ~baud_mode;
   // external flag on trigger capture or reload
   // in baud mode the trigger only sets the flag
   wire ext_set     = trig_evt;

   wire mode_var    = (serial_mode_i == ATCRB_SER_MODE1) | (serial_mode_i == ATCRB_SER_MODE3);
   wire [1:0] irq_stat = {ext_flag, ovf_flag};

   // count next value: software write beats hardware
   always_comb begin
      count_nxt = count_r;
      if (do_reload) begin
         count_nxt = hold_r;
      end else if (inc) begin
         count_nxt = count_r + 16'h0001;
      end
      if (wr_cnt_lo) begin
         count_nxt[7:0] = reg_wdata_i;
      end
      if (wr_cnt_hi) begin
         count_nxt[15:8] = reg_wdata_i;
      end
   end

   // holding pair next value
   always_comb begin
      hold_nxt = hold_r;
      if (do_capture) begin
         hold_nxt = count_r;
      end
      if (wr_hold_lo) begin
         hold_nxt[7:0] = reg_wdata_i;
      end
      if (wr_hold_hi) begin
         hold_nxt[15:8] = reg_wdata_i;
      end
   end

   // flags: a write of 0 or a clear-register 1 clears, set wins
   always_comb begin
      ovf_flag_nxt = ovf_flag;
      ext_flag_nxt = ext_flag;
      if (wr_ctrl & ~reg_wdata_i[ATCRB_B_OVF_FLAG]) begin
         ovf_flag_nxt = 1'b0;
      end
      if (wr_ctrl & ~reg_wdata_i[ATCRB_B_EXT_FLAG]) begin
         ext_flag_nxt = 1'b0;
      end
      if (wr_irq_clr & reg_wdata_i[ATCRB_I_OVF]) begin
         ovf_flag_nxt = 1'b0;
      end
      if (wr_irq_clr & reg_wdata_i[ATCRB_I_EXT]) begin
         ext_flag_nxt = 1'b0;
      end
      if (ovf_set) begin
         ovf_flag_nxt = 1'b1;
      end
      if (ext_set) begin
         ext_flag_nxt = 1'b1;
      end
   end

   // read mux, unmapped and write-only read zero
   wire [7:0] rd_mux =
      (reg_addr_i == ATCRB_ADDR_CONTROL)   ? ctrl_r :
      (reg_addr_i == ATCRB_ADDR_CNT_LOW)   ? count_r[7:0] :
      (reg_addr_i == ATCRB_ADDR_CNT_HIGH)  ? count_r[15:8] :
      (reg_addr_i == ATCRB_ADDR_HOLD_LOW)  ? hold_r[7:0] :
      (reg_addr_i == ATCRB_ADDR_HOLD_HIGH) ? hold_r[15:8] :
      (reg_addr_i == ATCRB_ADDR_IRQ_STAT)  ? {6'h00, irq_stat} :
      (reg_addr_i == ATCRB_ADDR_IRQ_EN)    ? {6'h00, irq_en_r} : 8'h00;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_r   <= ATCRB_RST_CONTROL;
         irq_en_r <= ATCRB_RST_IRQ_EN;
      end else begin
         if (wr_ctrl) begin
            ctrl_r[5:0] <= reg_wdata_i[5:0];
         end
         ctrl_r[ATCRB_B_OVF_FLAG] <= ovf_flag_nxt;
         ctrl_r[ATCRB_B_EXT_FLAG] <= ext_flag_nxt;
         if (wr_irq_en) begin
            irq_en_r <= reg_wdata_i[1:0];
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count_r <= ATCRB_RST_COUNT;
         hold_r  <= ATCRB_RST_HOLD;
      end else begin
         count_r <= count_nxt;
         hold_r  <= hold_nxt;
      end
   end

   // dividers and edge samplers
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mc_cnt_r     <= 4'h0;
         st_cnt_r     <= 1'b0;
         event_prev_r <= 1'b0;
         trig_prev_r  <= 1'b0;
      end else begin
         mc_cnt_r     <= mc_tick ? 4'h0 : mc_cnt_r + 4'h1;
         st_cnt_r     <= ~st_cnt_r;
         event_prev_r <= ext_event_pin_i;
         trig_prev_r  <= ext_trigger_pin_i;
      end
   end

   // outputs
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_r   <= 8'h00;
         rx_baud_r <= 1'b0;
         tx_baud_r <= 1'b0;
         own_ovf_r <= 1'b0;
         irq_r     <= 1'b0;
      end else begin
         rdata_r   <= reg_rd_i ? rd_mux : 8'h00;
         rx_baud_r <= mode_var & (rx_sel ? roll : other_timer_ovf_i);
         // serial side divides these pulses by 16
         tx_baud_r <= mode_var & (tx_sel ? roll : other_timer_ovf_i);
         own_ovf_r <= roll;
         irq_r     <= |(irq_stat & irq_en_r);
      end
   end

   assign reg_rdata_o   = rdata_r;
   assign rx_baud_clk_o = rx_baud_r;
   assign tx_baud_clk_o = tx_baud_r;
   assign own_ovf_o     = own_ovf_r;
   assign irq_o         = irq_r;

   // checks
   wire sw_cnt_wr = wr_cnt_lo | wr_cnt_hi;

   sequence s_reload_cause;
      roll & ~cap_mode & ~sw_cnt_wr;
   endsequence
   sequence s_loaded;
      count_r == $past(hold_r);
   endsequence

   property p_reload;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      s_reload_cause |=> s_loaded;
   endproperty
   a_reload: assert property (p_reload) else $error("overflow did not reload");

   property p_no_ovf_baud;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (baud_mode & ~ovf_flag) |=> ~ovf_flag;
   endproperty
   a_no_ovf_baud: assert property (p_no_ovf_baud) else $error("overflow flag set in baud mode");

   property p_hold_stopped;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (~run & ~sw_cnt_wr & ~trig_reload) |=> $stable(count_r);
   endproperty
   a_hold_stopped: assert property (p_hold_stopped) else $error("count moved while stopped");

   property p_capture;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (do_capture & ~wr_hold_lo & ~wr_hold_hi) |=> (hold_r == $past(count_r)) & ext_flag;
   endproperty
   a_capture: assert property (p_capture) else $error("capture failed");

   property p_trig_off;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (~ext_en & ~ext_flag) |=> ~ext_flag;
   endproperty
   a_trig_off: assert property (p_trig_off) else $error("ext flag set with trigger off");

   property p_baud_trig;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (baud_mode & trig_evt & ~inc & ~sw_cnt_wr) |=> ext_flag & $stable(count_r);
   endproperty
   a_baud_trig: assert property (p_baud_trig) else $error("baud trigger disturbed count");

   property p_rx_route;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (mode_var & ~rx_sel) |=> (rx_baud_clk_o == $past(other_timer_ovf_i));
   endproperty
   a_rx_route: assert property (p_rx_route) else $error("receive clock misrouted");

   property p_tx_route;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (mode_var & tx_sel) |=> (tx_baud_clk_o == $past(roll));
   endproperty
   a_tx_route: assert property (p_tx_route) else $error("transmit clock misrouted");

   // cycles since the last machine cycle tick
   logic [3:0] mc_gap_r;
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mc_gap_r <= 4'h0;
      end else begin
         mc_gap_r <= mc_tick ? 4'h0 : mc_gap_r + 4'h1;
      end
   end

   property p_mc_spacing;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      mc_tick == (mc_gap_r == ATCRB_MC_LAST);
   endproperty
   a_mc_spacing: assert property (p_mc_spacing) else $error("machine cycle not twelve clocks");

   property p_irq;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (|(irq_stat & irq_en_r)) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_irq_low;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (~|(irq_stat & irq_en_r)) |=> ~irq_o;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("interrupt raised without cause");

   property p_trig_reload;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (trig_reload & ~sw_cnt_wr) |=> s_loaded ##0 ext_flag;
   endproperty
   a_trig_reload: assert property (p_trig_reload) else $error("trigger did not reload");

   property p_baud_no_cap;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (baud_mode & trig_evt & ~wr_hold_lo & ~wr_hold_hi) |=> $stable(hold_r);
   endproperty
   a_baud_no_cap: assert property (p_baud_no_cap) else $error("holding pair moved in baud mode");

   property p_mode_gate;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      ~mode_var |=> ~rx_baud_clk_o & ~tx_baud_clk_o;
   endproperty
   a_mode_gate: assert property (p_mode_gate) else $error("baud pulse outside modes 1 and 3");

   property p_ovf_set;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (roll & ~baud_mode) |=> ovf_flag;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

   property p_count_inc;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (inc & ~roll & ~trig_reload & ~sw_cnt_wr) |=> count_r == $past(count_r) + 16'h0001;
   endproperty
   a_count_inc: assert property (p_count_inc) else $error("count did not step");
endmodule
`default_nettype wire

// ### bench/atcrb_far_model.sv
/*
 far-side model: serial port mode, other timer overflow, event pins.
 assumes the bench calls fall() from one process only.
*/
`timescale 1ns/1ps
`default_nettype none
module atcrb_far_model #(
   parameter int OTH_PER = 10
) (
   // clock
   input  wire logic       clk_i,
   // toward the timer
   output logic      [1:0] serial_mode_o,
   output logic            other_ovf_o,
   output logic            event_pin_o,
   output logic            trigger_pin_o
);
   int cnt = 0;
   initial begin
      serial_mode_o = 2'h1;
      other_ovf_o   = 1'b0;
      event_pin_o   = 1'b1;
      trigger_pin_o = 1'b1;
   end
   // other timer overflow, one cycle each period
   always @(posedge clk_i) begin
      cnt         <= (cnt == OTH_PER - 1) ? 0 : cnt + 1;
      other_ovf_o <= (cnt == OTH_PER - 1);
   end
   // one falling edge, held low two cycles
   task automatic fall(input bit trig);
      @(posedge clk_i);
      if (trig)
         trigger_pin_o <= 1'b0;
      else
         event_pin_o <= 1'b0;
      repeat (2) @(posedge clk_i);
      trigger_pin_o <= 1'b1;
      event_pin_o   <= 1'b1;
      repeat (2) @(posedge clk_i);
   endtask
   // serial port mode change, settled one edge later
   task automatic set_mode(input logic [1:0] m);
      @(posedge clk_i);
      serial_mode_o <= m;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// ### bench/tb_aux_timer_capture_reload_baud.sv
/*
 testbench of the auxiliary timer: register tasks, queued read checks.
 assumes read data one cycle after the strobe, far model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_aux_timer_capture_reload_baud;
   import atcrb_pkg::*;
   localparam int OTH = 10;
   logic        sys_clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, rd_d = 0;
   logic  [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic        rx_baud_clk_o, tx_baud_clk_o, own_ovf_o, irq_o;
   logic  [1:0] ser_mode;
   logic        oth_ovf, ev_pin, trig_pin;
   logic  [7:0] exp_q[$];
   logic [15:0] r;
   int          error_cnt = 0, checks = 0, n;
   int          seed = 32'hb2d394c2;
   atcrb_far_model #(.OTH_PER(OTH)) u_atcrb_far_model (.clk_i(sys_clk_i), .serial_mode_o(ser_mode),
      .other_ovf_o(oth_ovf), .event_pin_o(ev_pin), .trigger_pin_o(trig_pin));
   atcrb_top u_atcrb_top (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .ext_event_pin_i(ev_pin), .ext_trigger_pin_i(trig_pin), .serial_mode_i(ser_mode),
      .other_timer_ovf_i(oth_ovf), .rx_baud_clk_o(rx_baud_clk_o), .tx_baud_clk_o(tx_baud_clk_o),
      .own_ovf_o(own_ovf_o), .irq_o(irq_o));
   initial forever #25 sys_clk_i = ~sys_clk_i;
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic final_report;
      if (error_cnt == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      exp_q.push_back(e);
      @(posedge sys_clk_i);
      reg_rd_i   <= 1'b0;
   endtask
   // cycles between two pulses of rx, tx or own overflow
   task automatic gap(input int s, output int n);
      int   k;
      logic p;
      bit   st;
      n  = 0;
      st = 0;
      for (k = 0; k < 400; k++) begin
         @(negedge sys_clk_i);
         p = (s == 0) ? rx_baud_clk_o : (s == 1) ? tx_baud_clk_o : own_ovf_o;
         if (p === 1'b1 && st)
            break;
         if (p === 1'b1)
            st = 1;
         if (st)
            n++;
      end
      if (k == 400) begin
         chk("pulse wait", 8'h01, 8'h00);
         final_report();
      end
   endtask
   // read data monitor against the queue
   always @(posedge sys_clk_i) rd_d <= reg_rd_i;
   always @(negedge sys_clk_i) begin
      if (rd_d)
         chk("reg_rdata_o", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx, reg_rdata_o);
      else
         chk("reg_rdata_o idle", 8'h00, reg_rdata_o);
   end
   initial begin
      logic [7:0] a[9] = '{ATCRB_ADDR_CONTROL, ATCRB_ADDR_CNT_LOW, ATCRB_ADDR_CNT_HIGH, ATCRB_ADDR_HOLD_LOW,
         ATCRB_ADDR_HOLD_HIGH, ATCRB_ADDR_IRQ_STAT, ATCRB_ADDR_IRQ_CLR, ATCRB_ADDR_IRQ_EN, 8'hf0};
      repeat (5) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      foreach (a[i]) rd(a[i], 8'h00);
      wr(ATCRB_ADDR_HOLD_LOW, 8'hfe);
      wr(ATCRB_ADDR_HOLD_HIGH, 8'hff);
      wr(ATCRB_ADDR_CNT_LOW, 8'hff);
      wr(ATCRB_ADDR_CNT_HIGH, 8'hff);
      wr(ATCRB_ADDR_IRQ_EN, 8'h01);
      wr(ATCRB_ADDR_CONTROL, 8'h04);
      gap(2, n);
      chk("overflow period", 8'h18, 8'(n));
      rd(ATCRB_ADDR_CONTROL, 8'h84);
      rd(ATCRB_ADDR_CNT_LOW, 8'hfe);
      rd(ATCRB_ADDR_IRQ_STAT, 8'h01);
      wr(ATCRB_ADDR_CONTROL, 8'h80);
      @(negedge sys_clk_i);
      chk("irq_o", 8'h01, {7'h00, irq_o});
      wr(ATCRB_ADDR_IRQ_EN, 8'h00);
      repeat (2) @(negedge sys_clk_i);
      chk("irq_o", 8'h00, {7'h00, irq_o});
      wr(ATCRB_ADDR_IRQ_EN, 8'h01);
      repeat (2) @(negedge sys_clk_i);
      chk("irq_o", 8'h01, {7'h00, irq_o});
      wr(ATCRB_ADDR_IRQ_CLR, 8'h01);
      repeat (2) @(negedge sys_clk_i);
      chk("irq_o", 8'h00, {7'h00, irq_o});
      rd(ATCRB_ADDR_CONTROL, 8'h00);
      rd(ATCRB_ADDR_CNT_LOW, 8'hfe);
      wr(ATCRB_ADDR_CNT_LOW, 8'h00);
      wr(ATCRB_ADDR_CNT_HIGH, 8'h00);
      wr(ATCRB_ADDR_CONTROL, 8'h06);
      repeat (3) u_atcrb_far_model.fall(0);
      rd(ATCRB_ADDR_CNT_LOW, 8'h03);
      wr(ATCRB_ADDR_CONTROL, 8'h02);
      u_atcrb_far_model.fall(0);
      rd(ATCRB_ADDR_CNT_LOW, 8'h03);
      r = 16'($random(seed));
      wr(ATCRB_ADDR_CNT_LOW, r[7:0]);
      wr(ATCRB_ADDR_CNT_HIGH, r[15:8]);
      wr(ATCRB_ADDR_CONTROL, 8'h0f);
      u_atcrb_far_model.fall(1);
      rd(ATCRB_ADDR_HOLD_LOW, r[7:0]);
      rd(ATCRB_ADDR_HOLD_HIGH, r[15:8]);
      rd(ATCRB_ADDR_CONTROL, 8'h4f);
      wr(ATCRB_ADDR_HOLD_LOW, r[15:8]);
      wr(ATCRB_ADDR_CONTROL, 8'h0e);
      u_atcrb_far_model.fall(1);
      rd(ATCRB_ADDR_CNT_LOW, r[15:8]);
      rd(ATCRB_ADDR_CONTROL, 8'h4e);
      wr(ATCRB_ADDR_CONTROL, 8'h06);
      wr(ATCRB_ADDR_CNT_LOW, 8'h55);
      u_atcrb_far_model.fall(1);
      rd(ATCRB_ADDR_CNT_LOW, 8'h55);
      rd(ATCRB_ADDR_CONTROL, 8'h06);
      wr(ATCRB_ADDR_CONTROL, 8'h00);
      wr(ATCRB_ADDR_HOLD_LOW, 8'hec);
      wr(ATCRB_ADDR_HOLD_HIGH, 8'hff);
      wr(ATCRB_ADDR_CNT_LOW, 8'hec);
      wr(ATCRB_ADDR_CNT_HIGH, 8'hff);
      wr(ATCRB_ADDR_CONTROL, 8'h3d);
      gap(0, n);
      chk("rx period", 8'h28, 8'(n));
      gap(1, n);
      chk("tx period", 8'h28, 8'(n));
      u_atcrb_far_model.fall(1);
      rd(ATCRB_ADDR_CONTROL, 8'h7d);
      rd(ATCRB_ADDR_IRQ_STAT, 8'h02);
      wr(ATCRB_ADDR_IRQ_EN, 8'h02);
      repeat (2) @(negedge sys_clk_i);
      chk("irq_o", 8'h01, {7'h00, irq_o});
      rd(ATCRB_ADDR_HOLD_LOW, 8'hec);
      gap(1, n);
      chk("tx period", 8'h28, 8'(n));
      wr(ATCRB_ADDR_CONTROL, 8'h1d);
      gap(0, n);
      chk("rx period", 8'(OTH), 8'(n));
      gap(1, n);
      chk("tx period", 8'h28, 8'(n));
      // baud pulses gated off in serial mode 2
      u_atcrb_far_model.set_mode(2'h2);
      n = 0;
      repeat (60) begin
         @(negedge sys_clk_i);
         if (rx_baud_clk_o !== 1'b0 || tx_baud_clk_o !== 1'b0)
            n++;
      end
      chk("gated baud pulses", 8'h00, 8'(n));
      u_atcrb_far_model.set_mode(2'h3);
      gap(1, n);
      chk("tx period", 8'h28, 8'(n));
      rd(ATCRB_ADDR_CONTROL, 8'h1d);
      repeat (3) @(negedge sys_clk_i);
      final_report();
   end
endmodule
`default_nettype wire
